// file: scl_defines.vh
`ifndef SCL_DEFINES_VH
`define SCL_DEFINES_VH
`define SCL_WORD_BITS 24
`define SCL_ADDR_CTRL 2'b00
`define SCL_ADDR_REF 2'b01
`define SCL_ADDR_DIV 2'b10
`define SCL_ADDR_TEST 2'b11
`define SCL_C_PRESC_HI 23
`define SCL_C_PRESC_LO 22
`define SCL_C_PD_SYNC 21
`define SCL_C_PD_EN 20
`define SCL_C_CUR2_HI 19
`define SCL_C_CUR2_LO 17
`define SCL_C_CUR1_HI 16
`define SCL_C_CUR1_LO 14
`define SCL_C_PWR_HI 13
`define SCL_C_PWR_LO 12
`define SCL_C_MUTE 11
`define SCL_C_GAIN 10
`define SCL_C_TRI 9
`define SCL_C_POL 8
`define SCL_C_MUX_HI 7
`define SCL_C_MUX_LO 5
`define SCL_C_CLR 4
`define SCL_C_CORE_HI 3
`define SCL_C_CORE_LO 2
`define SCL_N_SRC_HALF 23
`define SCL_N_HALVE 22
`define SCL_N_GAIN 21
`define SCL_N_B_HI 20
`define SCL_N_B_LO 8
`define SCL_N_A_HI 6
`define SCL_N_A_LO 2
`define SCL_R_BAND_HI 21
`define SCL_R_BAND_LO 20
`define SCL_R_TEST 19
`define SCL_R_LOCK_CNT 18
`define SCL_R_ABL_HI 17
`define SCL_R_ABL_LO 16
`define SCL_R_REF_HI 15
`define SCL_R_REF_LO 2
`define SCL_LOCK_SHORT 3'd3
`define SCL_LOCK_LONG 3'd5
`define SCL_PD_SYNC_EDGES 2'd2
`endif

// file: scl_sync.v
`timescale 1ns/10ps
// Two-flop synchroniser, one per bit
module scl_sync #(
   parameter W = 1
) (
   input wire ref_clk_i, // Block clock
   input wire resetn_i, // Async reset, low
   input wire [W-1:0] d_i, // Asynchronous inputs
   output wire [W-1:0] q_o // Synchronised outputs
);
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1)
      begin : g_bit
         reg meta;
         reg stable;
         always @(posedge ref_clk_i or negedge resetn_i)
         begin
            if (!resetn_i)
            begin
               meta <= 1'b0;
               stable <= 1'b0;
            end
            else
            begin
               meta <= d_i[g];
               stable <= meta;
            end
         end
         assign q_o[g] = stable;
      end
   endgenerate
endmodule // scl_sync

// file: scl_shift.v
`timescale 1ns/10ps
`include "scl_defines.vh"
// Serial shift register fed by synchronised pins
module scl_shift (
   input wire ref_clk_i, // Block clock
   input wire resetn_i, // Async reset, low
   input wire sclk_i, // Synchronised serial clock
   input wire sdata_i, // Synchronised serial data
   input wire strobe_i, // Synchronised latch strobe
   output reg [`SCL_WORD_BITS-1:0] word_o, // Shifted word
   output reg load_o // One-cycle pulse on strobe rise
);
   reg sclk_d;
   reg strobe_d;
   reg [`SCL_WORD_BITS-1:0] shreg;
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sclk_d <= 1'b0;
         strobe_d <= 1'b0;
         shreg <= 24'h00_0000;
         word_o <= 24'h00_0000;
         load_o <= 1'b0;
      end
      else
      begin
         sclk_d <= sclk_i;
         strobe_d <= strobe_i;
         load_o <= 1'b0;
         // R24 - shift on rise
         if (sclk_i && !sclk_d)
            shreg <= {shreg[`SCL_WORD_BITS-2:0], sdata_i};
         // R24 - transfer on strobe
         if (strobe_i && !strobe_d)
         begin
            word_o <= shreg;
            load_o <= 1'b1;
         end
      end
   end
endmodule // scl_shift

// file: scl_latches.v
`timescale 1ns/10ps
`include "scl_defines.vh"
// Behaviour
// R1 - Two three-bit pump current settings stored
// R2 - Two-bit output power field stored
// R3 - Mute outputs until lock when enabled
// R4 - Gain bit picks current two or one
// R5 - Three-state bit floats charge pump
// R6 - Polarity bit: one positive, zero inverted
// R7 - Three-bit field selects monitor pin source
// R8 - Clear bit holds all counters reset; band_div_cnt is not cleared by it, only by power-down
// R9 - Address one-zero loads divider latch
// R10 - Five-bit A swallow counter, 0 to 31
// R11 - Thirteen-bit B counter, host 3..8191
// R12 - Division equals prescaler times B plus A
// R13 - Single gain copy, latest writer wins
// R14 - Halve bit enables output divide-by-two
// R15 - Source bit feeds prescaler from halved output
// R16 - Address zero-one loads reference latch
// R17 - Fourteen-bit reference divider, host 1..16383
// R18 - Two-bit antibacklash width field
// R19 - Lock after three or five good cycles
// R20 - Test gate zero ignores test latch
// R21 - Band clock from reference, optional divider
// R22 - Host writes spare bits as zero
// R23 - Address zero-zero loads control latch
// R24 - Shift 24 bits, strobe transfers word
// R25 - Async, sync and pin power-down
// R26 - Power-down resets counters, pump, lock
module scl_latches (
   input wire ref_clk_i, // Block clock, 200 MHz
   input wire resetn_i, // Async reset, low
   input wire sclk_pin_i, // Serial clock pin
   input wire sdata_pin_i, // Serial data pin
   input wire strobe_pin_i, // Latch strobe pin
   input wire chip_power_gate_i, // Chip power pin, low disables
   input wire ref_out_i, // Reference counter output
   input wire phase_ok_i, // Phase error under 15 ns this cycle
   output reg [2:0] pump_current_one_o, // Current setting one
   output reg [2:0] pump_current_two_o, // Current setting two
   output reg [2:0] pump_current_o, // Active pump current
   output reg pump_gain_select_o, // Stored gain bit
   output reg pump_three_state_o, // Pump high impedance
   output reg phase_polarity_o, // 1 positive polarity
   output reg [2:0] mux_pin_select_o, // Monitor pin source
   output reg [1:0] out_power_sel_o, // Output power level
   output reg [1:0] vco_core_current_o, // Core power level
   output reg [1:0] prescaler_sel_o, // Prescaler modulus code
   output reg rf_enable_o, // RF outputs on
   output reg counter_reset_o, // Counters held in load state
   output reg [4:0] a_count_o, // A swallow value
   output reg [12:0] b_count_o, // B value
   output reg [18:0] feedback_ratio_o, // P times B plus A
   output reg output_halve_o, // Output divide-by-two
   output reg prescaler_src_halved_o, // Prescaler from halved path
   output reg [13:0] ref_ratio_o, // Reference divide ratio
   output reg [1:0] antibacklash_width_o, // Antibacklash width
   output reg lock_count_select_o, // 1 five cycles, 0 three
   output reg [1:0] band_clock_div_o, // Band clock divider code
   output reg band_clock_o, // Band-select logic clock
   output reg locked_o, // Digital lock detect
   output reg monitor_output_pin_o, // Monitor multiplexer output
   output reg power_down_o // Device powered down
);
   wire [2:0] pins_s;
   wire sclk_s;
   wire sdata_s;
   wire strobe_s;
   wire ce_s;
   wire refo_s;
   wire [`SCL_WORD_BITS-1:0] word;
   wire load;
   wire [1:0] addr;
   reg [23:0] ctrl;
   reg [23:0] ndiv;
   reg [23:0] rdiv;
   reg [23:0] test_latch;
   reg gain;
   reg refo_d;
   reg sync_armed;
   reg [1:0] sync_edges;
   reg pd_soft;
   reg [2:0] good_cnt;
   reg [2:0] band_div_cnt;
   reg band_clk;
   reg [5:0] pmod;
   wire ref_rise;
   wire pd_now;
   wire [2:0] lock_need;
   wire [2:0] band_top;
   scl_sync #(.W(3)) u_pins (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .d_i({sclk_pin_i, sdata_pin_i, strobe_pin_i}),
      .q_o(pins_s)
   );
   scl_sync #(.W(2)) u_misc (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .d_i({chip_power_gate_i, ref_out_i}),
      .q_o({ce_s, refo_s})
   );
   assign sclk_s = pins_s[2];
   assign sdata_s = pins_s[1];
   assign strobe_s = pins_s[0];
   scl_shift u_shift (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .sclk_i(sclk_s),
      .sdata_i(sdata_s),
      .strobe_i(strobe_s),
      .word_o(word),
      .load_o(load)
   );
   assign addr = word[1:0];
   assign ref_rise = refo_s && !refo_d;
   // R25 - pin or soft power-down
   assign pd_now = !ce_s || pd_soft;
   // R19 - required good cycles
   assign lock_need = rdiv[`SCL_R_LOCK_CNT] ? `SCL_LOCK_LONG : `SCL_LOCK_SHORT;
   // R21 - divider code to period
   assign band_top = {1'b0, rdiv[`SCL_R_BAND_HI:`SCL_R_BAND_LO]};
   // Latch transfer; serial path stays live in power-down
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl <= 24'h00_0000;
         ndiv <= 24'h00_0000;
         rdiv <= 24'h00_0000;
         test_latch <= 24'h00_0000;
         gain <= 1'b0;
      end
      else if (load)
      begin
         case (addr)
            // R23 - control latch
            `SCL_ADDR_CTRL:
            begin
               ctrl <= word;
               // R13 - latest writer
               gain <= word[`SCL_C_GAIN];
            end
            // R9 - divider latch
            `SCL_ADDR_DIV:
            begin
               ndiv <= word;
               // R13 - latest writer
               gain <= word[`SCL_N_GAIN];
            end
            // R16 - reference latch
            `SCL_ADDR_REF:
               rdiv <= word;
            default:
               test_latch <= word;
         endcase
      end
   end
   // Power-down sequencing
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         refo_d <= 1'b0;
         sync_armed <= 1'b0;
         sync_edges <= 2'd0;
         pd_soft <= 1'b0;
      end
      else
      begin
         refo_d <= refo_s;
         if (load && addr == `SCL_ADDR_CTRL)
         begin
            // R25 - async or armed sync
            if (!word[`SCL_C_PD_EN])
            begin
               pd_soft <= 1'b0;
               sync_armed <= 1'b0;
            end
            else if (!word[`SCL_C_PD_SYNC])
            begin
               pd_soft <= 1'b1;
               sync_armed <= 1'b0;
            end
            else
            begin
               sync_armed <= 1'b1;
               sync_edges <= 2'd0;
            end
         end
         else if (sync_armed && ref_rise)
         begin
            // R25 - second reference rise
            if (sync_edges == `SCL_PD_SYNC_EDGES - 2'd1)
            begin
               pd_soft <= 1'b1;
               sync_armed <= 1'b0;
            end
            sync_edges <= sync_edges + 2'd1;
         end
      end
   end
   // Lock detect and band-select clock
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         good_cnt <= 3'd0;
         band_div_cnt <= 3'd0;
         band_clk <= 1'b0;
      end
      else
      begin
         // R26 - lock detect reset
         if (pd_now || ctrl[`SCL_C_CLR])
            good_cnt <= 3'd0;
         // R19 - consecutive good cycles
         else if (ref_rise)
         begin
            if (!phase_ok_i)
               good_cnt <= 3'd0;
            else if (good_cnt < lock_need)
               good_cnt <= good_cnt + 3'd1;
         end
         // R21 - optional band divider
         if (pd_now)
         begin
            band_div_cnt <= 3'd0;
            band_clk <= 1'b0;
         end
         else if (band_top == 3'd0)
            band_clk <= refo_s;
         else if (ref_rise)
         begin
            if (band_div_cnt >= band_top)
            begin
               band_div_cnt <= 3'd0;
               band_clk <= !band_clk;
            end
            else
               band_div_cnt <= band_div_cnt + 3'd1;
         end
      end
   end
   // Prescaler modulus from the two prescaler bits
   always @*
   begin
      case (ctrl[`SCL_C_PRESC_HI:`SCL_C_PRESC_LO])
         2'b00: pmod = 6'd8;
         2'b01: pmod = 6'd16;
         default: pmod = 6'd32;
      endcase
   end
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pump_current_one_o <= 3'd0;
         pump_current_two_o <= 3'd0;
         pump_current_o <= 3'd0;
         pump_gain_select_o <= 1'b0;
         pump_three_state_o <= 1'b1;
         phase_polarity_o <= 1'b0;
         mux_pin_select_o <= 3'd0;
         out_power_sel_o <= 2'd0;
         vco_core_current_o <= 2'd0;
         prescaler_sel_o <= 2'd0;
         rf_enable_o <= 1'b0;
         counter_reset_o <= 1'b1;
         a_count_o <= 5'd0;
         b_count_o <= 13'd0;
         feedback_ratio_o <= 19'd0;
         output_halve_o <= 1'b0;
         prescaler_src_halved_o <= 1'b0;
         ref_ratio_o <= 14'd0;
         antibacklash_width_o <= 2'd0;
         lock_count_select_o <= 1'b0;
         band_clock_div_o <= 2'd0;
         band_clock_o <= 1'b0;
         locked_o <= 1'b0;
         monitor_output_pin_o <= 1'b0;
         power_down_o <= 1'b1;
      end
      else
      begin
         // R1 - two current settings
         pump_current_one_o <= ctrl[`SCL_C_CUR1_HI:`SCL_C_CUR1_LO];
         pump_current_two_o <= ctrl[`SCL_C_CUR2_HI:`SCL_C_CUR2_LO];
         // R4 - gain selects setting
         pump_current_o <= gain ?
            ctrl[`SCL_C_CUR2_HI:`SCL_C_CUR2_LO] :
            ctrl[`SCL_C_CUR1_HI:`SCL_C_CUR1_LO];
         pump_gain_select_o <= gain;
         // R5 - three-state, forced in power-down
         pump_three_state_o <= ctrl[`SCL_C_TRI] || pd_now;
         // R6 - polarity
         phase_polarity_o <= ctrl[`SCL_C_POL];
         // R7 - monitor source
         mux_pin_select_o <= ctrl[`SCL_C_MUX_HI:`SCL_C_MUX_LO];
         // R2 - output power
         out_power_sel_o <= ctrl[`SCL_C_PWR_HI:`SCL_C_PWR_LO];
         vco_core_current_o <= ctrl[`SCL_C_CORE_HI:`SCL_C_CORE_LO];
         prescaler_sel_o <= ctrl[`SCL_C_PRESC_HI:`SCL_C_PRESC_LO];
         // R3 - mute until lock
         rf_enable_o <= !pd_now &&
            (!ctrl[`SCL_C_MUTE] || good_cnt >= lock_need);
         // R8 - counter clear; R26 - load state
         counter_reset_o <= ctrl[`SCL_C_CLR] || pd_now;
         // R10 - A value
         a_count_o <= ndiv[`SCL_N_A_HI:`SCL_N_A_LO];
         // R11 - B value
         b_count_o <= ndiv[`SCL_N_B_HI:`SCL_N_B_LO];
         // R12 - P times B plus A
         feedback_ratio_o <= pmod * ndiv[`SCL_N_B_HI:`SCL_N_B_LO] +
            {14'd0, ndiv[`SCL_N_A_HI:`SCL_N_A_LO]};
         // R14 - output halving
         output_halve_o <= ndiv[`SCL_N_HALVE];
         // R15 - prescaler source
         prescaler_src_halved_o <= ndiv[`SCL_N_SRC_HALF];
         // R17 - reference ratio
         ref_ratio_o <= rdiv[`SCL_R_REF_HI:`SCL_R_REF_LO];
         // R18 - antibacklash width
         antibacklash_width_o <= rdiv[`SCL_R_ABL_HI:`SCL_R_ABL_LO];
         lock_count_select_o <= rdiv[`SCL_R_LOCK_CNT];
         band_clock_div_o <= rdiv[`SCL_R_BAND_HI:`SCL_R_BAND_LO];
         band_clock_o <= band_clk;
         locked_o <= good_cnt >= lock_need;
         // R20 - test latch only with gate set
         case (mux_pin_select_o)
            3'd1: monitor_output_pin_o <= good_cnt >= lock_need;
            3'd2: monitor_output_pin_o <= refo_s;
            3'd3: monitor_output_pin_o <= band_clk;
            3'd7: monitor_output_pin_o <= rdiv[`SCL_R_TEST] &&
                                          test_latch[2];
            default: monitor_output_pin_o <= 1'b0;
         endcase
         power_down_o <= pd_now;
      end
   end
endmodule // scl_latches

// file: scl_latches_assertions.sv
`timescale 1ns/10ps
module scl_latches_assertions (
   input wire ref_clk_i, // Block clock
   input wire resetn_i, // Async reset, low
   input wire chip_power_gate_i, // Chip power pin
   input wire ref_out_i, // Reference output
   input wire phase_ok_i, // Phase error small
   input wire [2:0] pump_current_one_o, // Setting one
   input wire [2:0] pump_current_two_o, // Setting two
   input wire [2:0] pump_current_o, // Active current
   input wire pump_gain_select_o, // Gain bit
   input wire pump_three_state_o, // Pump floating
   input wire [1:0] prescaler_sel_o, // Modulus code
   input wire rf_enable_o, // RF on
   input wire counter_reset_o, // Counters held
   input wire [4:0] a_count_o, // A value
   input wire [12:0] b_count_o, // B value
   input wire [18:0] feedback_ratio_o, // Total division
   input wire lock_count_select_o, // Lock count pick
   input wire locked_o, // Lock detect
   input wire [2:0] mux_pin_select_o, // Monitor source
   input wire monitor_output_pin_o, // Monitor pin
   input wire power_down_o // Powered down
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!resetn_i);
   logic ref_q;
   logic [2:0] good;
   // Raw edges lead the synced ones, so this count never lags
   always @(posedge ref_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         ref_q <= 1'b0;
         good <= 3'd0;
      end
      else
      begin
         ref_q <= ref_out_i;
         if (ref_out_i && !ref_q)
            good <= !phase_ok_i ? 3'd0 : (good == 3'd7 ? good : good + 3'd1);
      end
   property p_pd_pump;
      power_down_o [*2] |-> pump_three_state_o && counter_reset_o;
   endproperty
   a_pd_pump: assert property (p_pd_pump)
      else $error("Pump or counters live in power-down");
   property p_pd_rf;
      power_down_o [*2] |-> !rf_enable_o && !locked_o;
   endproperty
   a_pd_rf: assert property (p_pd_rf)
      else $error("RF or lock live in power-down");
   property p_chip_off;
      !chip_power_gate_i [*5] |-> power_down_o;
   endproperty
   a_chip_off: assert property (p_chip_off)
      else $error("Chip power pin low ignored");
   property p_ratio;
      ($stable(prescaler_sel_o) && $stable(b_count_o) && $stable(a_count_o))
         [*2] |-> feedback_ratio_o == (prescaler_sel_o == 2'd0 ? 19'd8 :
         prescaler_sel_o == 2'd1 ? 19'd16 : 19'd32) * b_count_o + a_count_o;
   endproperty
   a_ratio: assert property (p_ratio)
      else $error("Feedback ratio wrong");
   property p_pump_sel;
      ($stable(pump_current_one_o) && $stable(pump_current_two_o) &&
         $stable(pump_gain_select_o)) [*2] |-> pump_current_o ==
         (pump_gain_select_o ? pump_current_two_o : pump_current_one_o);
   endproperty
   a_pump_sel: assert property (p_pump_sel)
      else $error("Active pump current wrong");
   property p_mux_lock;
      (mux_pin_select_o == 3'd1 && $stable(locked_o)) [*3]
         |-> monitor_output_pin_o == locked_o;
   endproperty
   a_mux_lock: assert property (p_mux_lock)
      else $error("Monitor pin not lock");
   property p_mux_zero;
      (mux_pin_select_o inside {3'd0, 3'd4, 3'd5, 3'd6}) [*3]
         |-> !monitor_output_pin_o;
   endproperty
   a_mux_zero: assert property (p_mux_zero)
      else $error("Monitor pin not low");
   property p_lock_cnt;
      $rose(locked_o) |-> good >= (lock_count_select_o ? 3'd5 : 3'd3);
   endproperty
   a_lock_cnt: assert property (p_lock_cnt)
      else $error("Lock declared too early");
endmodule // scl_latches_assertions

// file: scl_host_model.sv
`timescale 1ns/10ps
module scl_host_model (
   output logic sclk_o, // Serial clock, idle low
   output logic sdata_o, // Serial data
   output logic strobe_o // Latch strobe
);
   localparam HALF = 24;
   initial
   begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      strobe_o = 1'b0;
   end
   task send(input logic [23:0] w);
      logic [23:0] v;
      begin
         v = w;
         if (w[1:0] == 2'b10)
            v[7] = 1'b0;
         if (w[1:0] == 2'b01)
            v[23:22] = 2'b00;
         for (int i = 23; i >= 0; i--)
         begin
            sdata_o = v[i];
            #HALF sclk_o = 1'b1;
            #HALF sclk_o = 1'b0;
         end
         // Released line must not keep the last bit
         sdata_o = ~v[0];
         #HALF strobe_o = 1'b1;
         #(2*HALF) strobe_o = 1'b0;
         #HALF;
      end
   endtask
endmodule // scl_host_model

// file: scl_latches_tb.sv
`timescale 1ns/10ps
module scl_latches_tb;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic chip_power_gate_i = 1'b1;
   logic ref_out_i = 1'b0;
   logic phase_ok_i = 1'b0;
   wire sclk_pin_i, sdata_pin_i, strobe_pin_i;
   wire [2:0] pump_current_one_o, pump_current_two_o, pump_current_o;
   wire [2:0] mux_pin_select_o;
   wire [1:0] out_power_sel_o, vco_core_current_o, prescaler_sel_o;
   wire [1:0] antibacklash_width_o, band_clock_div_o;
   wire [4:0] a_count_o;
   wire [12:0] b_count_o;
   wire [18:0] feedback_ratio_o;
   wire [13:0] ref_ratio_o;
   wire pump_gain_select_o, pump_three_state_o, phase_polarity_o;
   wire rf_enable_o, counter_reset_o, output_halve_o;
   wire prescaler_src_halved_o, lock_count_select_o, band_clock_o;
   wire locked_o, monitor_output_pin_o, power_down_o;
   int error_cnt = 0;
   int n_tests = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   scl_host_model u_scl_host_model (
      .sclk_o(sclk_pin_i),
      .sdata_o(sdata_pin_i),
      .strobe_o(strobe_pin_i)
   );
   scl_latches u_scl_latches (.ref_clk_i, .resetn_i, .sclk_pin_i,
      .sdata_pin_i, .strobe_pin_i, .chip_power_gate_i, .ref_out_i,
      .phase_ok_i, .pump_current_one_o, .pump_current_two_o,
      .pump_current_o, .pump_gain_select_o, .pump_three_state_o,
      .phase_polarity_o, .mux_pin_select_o, .out_power_sel_o,
      .vco_core_current_o, .prescaler_sel_o, .rf_enable_o,
      .counter_reset_o, .a_count_o, .b_count_o, .feedback_ratio_o,
      .output_halve_o, .prescaler_src_halved_o, .ref_ratio_o,
      .antibacklash_width_o, .lock_count_select_o, .band_clock_div_o,
      .band_clock_o, .locked_o, .monitor_output_pin_o, .power_down_o);
   task chk(input string s, input logic [31:0] e, g);
      n_tests++;
      if (e !== g)
      begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", s, e, g);
      end
   endtask
   function logic [23:0] cw(input logic [2:0] m, input logic pe, ps, mt, g, h);
      cw = {2'b01, ps, pe, 3'b010, 3'b101, 2'b11, mt, g, h, 1'b1, m, h,
         2'b10, 2'b00};
   endfunction
   task wr(input logic [23:0] w);
      u_scl_host_model.send(w);
      repeat (4) @(negedge ref_clk_i);
   endtask
   // Expected band clock level is given: dividers and power-down alter it
   task pulses(input int n, input logic eb);
      repeat (n)
      begin
         @(negedge ref_clk_i);
         phase_ok_i = 1'b1;
         repeat (8) @(negedge ref_clk_i);
         ref_out_i = 1'b1;
         repeat (8) @(negedge ref_clk_i);
         chk("band_clk", eb, band_clock_o);
         ref_out_i = 1'b0;
      end
      repeat (8) @(negedge ref_clk_i);
   endtask
   task t_ctrl;
      wr(cw(3'd1, 0, 0, 0, 1, 0));
      chk("cur_one", 5, pump_current_one_o);
      chk("cur_two", 2, pump_current_two_o);
      chk("cur", 2, pump_current_o);
      chk("power", 3, out_power_sel_o);
      chk("polarity", 1, phase_polarity_o);
      chk("mux", 1, mux_pin_select_o);
      chk("core", 2, vco_core_current_o);
      chk("presc", 1, prescaler_sel_o);
      chk("tri", 0, pump_three_state_o);
      chk("clr", 0, counter_reset_o);
      wr(cw(3'd1, 0, 0, 0, 0, 1));
      chk("cur", 5, pump_current_o);
      chk("tri", 1, pump_three_state_o);
      chk("clr", 1, counter_reset_o);
   endtask
   task t_div;
      wr({3'b111, 13'd3, 1'b0, 5'd31, 2'b10});
      chk("a", 31, a_count_o);
      chk("b", 3, b_count_o);
      chk("ratio", 79, feedback_ratio_o);
      chk("halve", 1, output_halve_o);
      chk("src", 1, prescaler_src_halved_o);
      chk("gain", 1, pump_gain_select_o);
      chk("cur", 2, pump_current_o);
      wr({3'b000, 13'd8191, 1'b1, 5'd0, 2'b10});
      chk("a", 0, a_count_o);
      chk("b", 8191, b_count_o);
      chk("ratio", 131056, feedback_ratio_o);
      chk("halve", 0, output_halve_o);
      chk("src", 0, prescaler_src_halved_o);
      chk("gain", 0, pump_gain_select_o);
      wr(cw(3'd1, 0, 0, 0, 1, 0));
      chk("gain", 1, pump_gain_select_o);
   endtask
   task t_ref;
      wr({4'b0011, 1'b0, 1'b1, 2'b10, 14'd16383, 2'b01});
      chk("r", 16383, ref_ratio_o);
      chk("abl", 2, antibacklash_width_o);
      chk("ldp", 1, lock_count_select_o);
      chk("band", 3, band_clock_div_o);
      pulses(3, 0);
      pulses(1, 1);
      wr({4'b0000, 1'b0, 1'b0, 2'b01, 14'd1, 2'b01});
      chk("r", 1, ref_ratio_o);
      chk("abl", 1, antibacklash_width_o);
      chk("band", 0, band_clock_div_o);
      wr({21'd0, 3'b111});
      wr(cw(3'd7, 0, 0, 0, 1, 0));
      chk("mon", 0, monitor_output_pin_o);
      chk("r", 1, ref_ratio_o);
      wr(cw(3'd2, 0, 0, 0, 1, 0));
      // Bad phase on this edge also clears the good-cycle count
      phase_ok_i = 1'b0;
      ref_out_i = 1'b1;
      repeat (8) @(negedge ref_clk_i);
      chk("mon", 1, monitor_output_pin_o);
      ref_out_i = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      chk("mon", 0, monitor_output_pin_o);
   endtask
   task t_lock;
      wr(cw(3'd1, 0, 0, 1, 1, 0));
      chk("rf", 0, rf_enable_o);
      pulses(2, 1);
      chk("lock", 0, locked_o);
      pulses(1, 1);
      chk("lock", 1, locked_o);
      chk("rf", 1, rf_enable_o);
      chk("mon", 1, monitor_output_pin_o);
      chip_power_gate_i = 1'b0;
      wr({4'b0000, 1'b0, 1'b1, 2'b01, 14'd1, 2'b01});
      chk("ldp", 1, lock_count_select_o);
      chk("pd", 1, power_down_o);
      chk("lock", 0, locked_o);
      chk("tri", 1, pump_three_state_o);
      chk("clr", 1, counter_reset_o);
      chip_power_gate_i = 1'b1;
      repeat (8) @(negedge ref_clk_i);
      chk("pd", 0, power_down_o);
      pulses(4, 1);
      chk("lock", 0, locked_o);
      pulses(1, 1);
      chk("lock", 1, locked_o);
   endtask
   task t_pd;
      wr(cw(3'd1, 1, 0, 0, 1, 0));
      chk("pd", 1, power_down_o);
      wr(cw(3'd1, 0, 0, 0, 1, 0));
      chk("pd", 0, power_down_o);
      wr(cw(3'd1, 1, 1, 0, 1, 0));
      pulses(1, 1);
      chk("pd", 0, power_down_o);
      // Band clock is held low once power-down takes effect
      pulses(1, 0);
      chk("pd", 1, power_down_o);
   endtask
   task results;
      if (error_cnt == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      t_ctrl;
      t_div;
      t_ref;
      t_lock;
      t_pd;
      results;
   end
   // About 15 writes of 1.3 us each
   initial
   begin
      #100000;
      error_cnt++;
      results;
   end
endmodule // scl_latches_tb
bind scl_latches scl_latches_assertions u_chk (.ref_clk_i, .resetn_i,
   .chip_power_gate_i, .ref_out_i, .phase_ok_i, .pump_current_one_o,
   .pump_current_two_o, .pump_current_o, .pump_gain_select_o,
   .pump_three_state_o, .prescaler_sel_o, .rf_enable_o, .counter_reset_o,
   .a_count_o, .b_count_o, .feedback_ratio_o, .lock_count_select_o,
   .locked_o, .mux_pin_select_o, .monitor_output_pin_o, .power_down_o);
